// File: fspc_pkg.sv
// Summary of operation
// - Unmasked interrupt while enabled suspends rewrite; rewrite resumes once mode restored.
// - Interrupt response latency differs while in self programming mode.
// - Normal power mode permits rewriting of the program area.
// - Low power mode permits data area rewrites only, refuses program area.
// - Data written in low power mode is unreadable in normal power mode.
// - Written blocks cannot be overwritten; erase the block before writing.
// - Mode control register accepts single-bit and whole-byte writes.
// - Any reset clears the mode control register to zero.
// - Bit 0 selects normal (0) or self programming (1); bits 7..1 are zero.
// - With enable bit 0 the rewrite circuit stays inactive; flash unchanged.
package fspc_pkg;
  localparam logic [15:0] SPMC_ADDR   = 16'hff2b;
  localparam logic [7:0]  SPMC_RESET  = 8'h00;
  localparam int          EN_BIT      = 0;
  localparam logic [2:0]  BIT_IDX_W   = 3'h0;

  // Flash operation request from the rewrite firmware
  typedef struct packed {
    logic       erase;
    logic       write;
    logic       prog_area;
    logic       lp_written;
    logic       blank;
  } fspc_req_t;

  // Gated strobes toward the flash array
  typedef struct packed {
    logic       erase;
    logic       write;
  } fspc_cmd_t;

  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_ACTIVE,
    ST_SUSPEND
  } fspc_state_t;
endpackage

// File: fspc_ctrl.sv
`timescale 1ns/1ps
module fspc_ctrl (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // CPU special function register access
  input  wire logic [15:0]          sfr_addr,
  input  wire logic                 sfr_wr_byte,
  input  wire logic                 sfr_wr_bit,
  input  wire logic [2:0]           sfr_bit_idx,
  input  wire logic [7:0]           sfr_wdata,
  output logic      [7:0]           sfr_rdata,
  // System state
  input  wire logic                 global_interrupt_enable_flag,
  input  wire logic                 irq_unmasked,
  input  wire logic                 irq_return,
  input  wire logic                 low_power_mode,
  input  wire fspc_pkg::fspc_req_t  flash_req,
  // Toward flash array and CPU
  output fspc_pkg::fspc_cmd_t       flash_cmd,
  output logic                      rewrite_refused,
  output logic                      irq_branch,
  output logic                      self_prog_mode,
  output logic                      lp_read_block
);

  logic                  rewrite_enable_bit_ff;
  logic                  nxt_enable;
  fspc_pkg::fspc_state_t state_ff;
  fspc_pkg::fspc_state_t nxt_state;
  fspc_pkg::fspc_cmd_t   flash_cmd_ff;
  logic                  refused_ff;
  logic                  hit;
  logic                  allowed;

  assign hit = (sfr_addr == fspc_pkg::SPMC_ADDR);

  // Bit writes to bits 7..1 simply fall away
  always_comb begin
    nxt_enable = rewrite_enable_bit_ff;
    if (hit && sfr_wr_byte) begin
      nxt_enable = sfr_wdata[fspc_pkg::EN_BIT];
    end else if (hit && sfr_wr_bit && sfr_bit_idx == fspc_pkg::BIT_IDX_W) begin
      nxt_enable = sfr_wdata[fspc_pkg::EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rewrite_enable_bit_ff <= fspc_pkg::SPMC_RESET[fspc_pkg::EN_BIT];
    end else begin
      rewrite_enable_bit_ff <= nxt_enable;
    end
  end

  // Upper bits come from the reset constant, so they can never read back nonzero
  assign sfr_rdata = {fspc_pkg::SPMC_RESET[7:1], rewrite_enable_bit_ff};

  // Suspend on interrupt, resume once the handler returns with mode still set
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      fspc_pkg::ST_NORMAL: begin
        if (rewrite_enable_bit_ff) nxt_state = fspc_pkg::ST_ACTIVE;
      end
      fspc_pkg::ST_ACTIVE: begin
        if (!rewrite_enable_bit_ff) nxt_state = fspc_pkg::ST_NORMAL;
        else if (global_interrupt_enable_flag && irq_unmasked) begin
          nxt_state = fspc_pkg::ST_SUSPEND;
        end
      end
      fspc_pkg::ST_SUSPEND: begin
        if (!rewrite_enable_bit_ff) nxt_state = fspc_pkg::ST_NORMAL;
        else if (irq_return) nxt_state = fspc_pkg::ST_ACTIVE;
      end
      default: nxt_state = fspc_pkg::ST_NORMAL;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= fspc_pkg::ST_NORMAL;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Branch taken the cycle the request is seen, skipping normal fetch path
  assign irq_branch = (state_ff == fspc_pkg::ST_ACTIVE)
                   && (nxt_state == fspc_pkg::ST_SUSPEND);
  assign self_prog_mode = rewrite_enable_bit_ff;

  // Program area locked in low power; overwrite of a written block refused
  // Enable checked directly too, so a clear blocks the very next request
  assign allowed = (state_ff == fspc_pkg::ST_ACTIVE)
                 && rewrite_enable_bit_ff
                 && !(low_power_mode && flash_req.prog_area)
                 && !(flash_req.write && !flash_req.blank);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flash_cmd_ff <= '0;
      refused_ff   <= 1'b0;
    end else begin
      flash_cmd_ff.erase <= flash_req.erase && allowed;
      flash_cmd_ff.write <= flash_req.write && allowed;
      refused_ff         <= (flash_req.erase || flash_req.write) && !allowed;
    end
  end

  assign flash_cmd       = flash_cmd_ff;
  assign rewrite_refused = refused_ff;
  assign lp_read_block   = !low_power_mode && flash_req.lp_written;

  // Register access checks
  a_reset_clears: assert property (@(posedge clk)
    $rose(resetn) |-> sfr_rdata == fspc_pkg::SPMC_RESET)
    else $error("register not clear after reset");

  a_reset_state: assert property (@(posedge clk)
    $rose(resetn) |-> state_ff == fspc_pkg::ST_NORMAL)
    else $error("state not normal after reset");

  a_upper_bits_zero: assert property (@(posedge clk) disable iff (!resetn)
    sfr_rdata[7:1] == fspc_pkg::SPMC_RESET[7:1])
    else $error("upper bits nonzero");

  a_byte_write: assert property (@(posedge clk) disable iff (!resetn)
    hit && sfr_wr_byte |=> sfr_rdata[0] == $past(sfr_wdata[0]))
    else $error("byte write lost");

  a_bit_write: assert property (@(posedge clk) disable iff (!resetn)
    hit && sfr_wr_bit && !sfr_wr_byte && sfr_bit_idx == fspc_pkg::BIT_IDX_W
    |=> sfr_rdata[0] == $past(sfr_wdata[0]))
    else $error("bit write lost");

  a_bit_other: assert property (@(posedge clk) disable iff (!resetn)
    hit && sfr_wr_bit && !sfr_wr_byte && sfr_bit_idx != fspc_pkg::BIT_IDX_W
    |=> rewrite_enable_bit_ff == $past(rewrite_enable_bit_ff))
    else $error("bit write to fixed bit took effect");

  a_wrong_addr: assert property (@(posedge clk) disable iff (!resetn)
    !hit |=> rewrite_enable_bit_ff == $past(rewrite_enable_bit_ff))
    else $error("write at other address took effect");

  a_mode_bit: assert property (@(posedge clk) disable iff (!resetn)
    self_prog_mode == sfr_rdata[0])
    else $error("mode output mismatch");

  // Rewrite gating and low power read blocking checks
  a_inactive_off: assert property (@(posedge clk) disable iff (!resetn)
    !self_prog_mode |=> flash_cmd == '0)
    else $error("flash changed in normal mode");

  a_inactive_refuse: assert property (@(posedge clk) disable iff (!resetn)
    !rewrite_enable_bit_ff && (flash_req.erase || flash_req.write) |=> rewrite_refused)
    else $error("request in normal mode not refused");

  a_refuse_idle: assert property (@(posedge clk) disable iff (!resetn)
    !flash_req.erase && !flash_req.write |=> !rewrite_refused && flash_cmd == '0)
    else $error("strobe without request");

  a_clear_normal: assert property (@(posedge clk) disable iff (!resetn)
    !rewrite_enable_bit_ff && state_ff != fspc_pkg::ST_NORMAL
    |=> state_ff == fspc_pkg::ST_NORMAL)
    else $error("cleared enable did not return to normal");

  a_lp_prog_lock: assert property (@(posedge clk) disable iff (!resetn)
    low_power_mode && flash_req.prog_area |=> flash_cmd == '0)
    else $error("program area rewritten in low power");

  sequence s_clean_erase;
    state_ff == fspc_pkg::ST_ACTIVE && rewrite_enable_bit_ff
      && flash_req.erase && !(flash_req.write && !flash_req.blank);
  endsequence

  a_np_prog_ok: assert property (@(posedge clk) disable iff (!resetn)
    s_clean_erase ##0 !low_power_mode |=> flash_cmd.erase)
    else $error("program erase refused in normal power");

  a_lp_data_ok: assert property (@(posedge clk) disable iff (!resetn)
    s_clean_erase ##0 low_power_mode && !flash_req.prog_area |=> flash_cmd.erase)
    else $error("data erase refused in low power");

  a_no_overwrite: assert property (@(posedge clk) disable iff (!resetn)
    flash_req.write && !flash_req.blank |=> !flash_cmd.write && rewrite_refused)
    else $error("overwrite of written block");

  a_lp_read: assert property (@(posedge clk) disable iff (!resetn)
    flash_req.lp_written && !low_power_mode |-> lp_read_block)
    else $error("low power data readable");

  a_read_open: assert property (@(posedge clk) disable iff (!resetn)
    low_power_mode |-> !lp_read_block)
    else $error("read blocked in low power");

  // Interrupt suspend and resume checks
  sequence s_irq_in_rewrite;
    state_ff == fspc_pkg::ST_ACTIVE && rewrite_enable_bit_ff
      && global_interrupt_enable_flag && irq_unmasked;
  endsequence

  sequence s_suspended;
    state_ff == fspc_pkg::ST_SUSPEND;
  endsequence

  a_irq_suspend: assert property (@(posedge clk) disable iff (!resetn)
    s_irq_in_rewrite |-> irq_branch ##1 state_ff == fspc_pkg::ST_SUSPEND)
    else $error("interrupt did not suspend rewrite");

  a_no_branch_idle: assert property (@(posedge clk) disable iff (!resetn)
    state_ff != fspc_pkg::ST_ACTIVE |-> !irq_branch)
    else $error("branch outside rewrite");

  a_masked_irq: assert property (@(posedge clk) disable iff (!resetn)
    !global_interrupt_enable_flag |-> !irq_branch)
    else $error("branch with interrupts disabled");

  a_suspend_hold: assert property (@(posedge clk) disable iff (!resetn)
    s_suspended |=> flash_cmd == '0)
    else $error("flash rewritten while suspended");

  a_resume: assert property (@(posedge clk) disable iff (!resetn)
    s_suspended ##0 rewrite_enable_bit_ff && irq_return
    |=> state_ff == fspc_pkg::ST_ACTIVE)
    else $error("rewrite did not resume");
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                clk = 1'b0;
  logic                resetn = 1'b0;
  logic [15:0]         sfr_addr = 16'hff2b;
  logic                sfr_wr_byte = 1'b0;
  logic                sfr_wr_bit = 1'b0;
  logic [2:0]          sfr_bit_idx = 3'h0;
  logic [7:0]          sfr_wdata = 8'h00;
  logic [7:0]          sfr_rdata;
  logic                gie = 1'b0;
  logic                irq_unmasked = 1'b0;
  logic                irq_return = 1'b0;
  logic                low_power_mode = 1'b0;
  fspc_pkg::fspc_req_t flash_req = '0;
  fspc_pkg::fspc_cmd_t flash_cmd;
  logic                rewrite_refused;
  logic                irq_branch;
  logic                self_prog_mode;
  logic                lp_read_block;
  int                  fail_count = 0;
  int                  total_checks = 0;

  always #25 clk = ~clk;

  fspc_ctrl fspc_ctrl_inst (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
    .sfr_wr_byte(sfr_wr_byte), .sfr_wr_bit(sfr_wr_bit), .sfr_bit_idx(sfr_bit_idx),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .global_interrupt_enable_flag(gie),
    .irq_unmasked(irq_unmasked), .irq_return(irq_return), .low_power_mode(low_power_mode),
    .flash_req(flash_req), .flash_cmd(flash_cmd), .rewrite_refused(rewrite_refused),
    .irq_branch(irq_branch), .self_prog_mode(self_prog_mode), .lp_read_block(lp_read_block));

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic byt, input logic [2:0] idx, input logic [7:0] d);
    @(negedge clk);
    sfr_wr_byte = byt;
    sfr_wr_bit = ~byt;
    sfr_bit_idx = idx;
    sfr_wdata = d;
    @(negedge clk);
    sfr_wr_byte = 1'b0;
    sfr_wr_bit = 1'b0;
  endtask

  // Result packed as {erase, write, refused}
  task req(input fspc_pkg::fspc_req_t r, input logic [7:0] exp);
    @(negedge clk);
    flash_req = r;
    @(negedge clk);
    flash_req = '0;
    chk({5'h00, flash_cmd, rewrite_refused}, exp);
  endtask

  task end_sim;
    $display("Checks: %0d, mismatches: %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    chk(sfr_rdata, 8'h00);
    req(5'h15, 8'h01);
    wr(1'b1, 3'h0, 8'hff);
    chk(sfr_rdata, 8'h01);
    chk({7'h00, self_prog_mode}, 8'h01);
    req(5'h15, 8'h04);
    req(5'h0d, 8'h02);
    req(5'h0c, 8'h01);
    wr(1'b0, 3'h0, 8'h00);
    chk(sfr_rdata, 8'h00);
    wr(1'b0, 3'h5, 8'h01);
    chk(sfr_rdata, 8'h00);
    wr(1'b0, 3'h0, 8'h01);
    chk(sfr_rdata, 8'h01);
    sfr_addr = 16'hff2a;
    wr(1'b1, 3'h0, 8'h00);
    chk(sfr_rdata, 8'h01);
    sfr_addr = 16'hff2b;
    $display("Register and power tests done");
    low_power_mode = 1'b1;
    // Settle time after entering low power; regulator mode left alone
    repeat (40000) @(negedge clk);
    req(5'h0d, 8'h01);
    req(5'h09, 8'h02);
    @(negedge clk);
    flash_req = 5'h02;
    #1 chk({7'h00, lp_read_block}, 8'h00);
    low_power_mode = 1'b0;
    #1 chk({7'h00, lp_read_block}, 8'h01);
    flash_req = '0;
    irq_unmasked = 1'b1;
    #1 chk({7'h00, irq_branch}, 8'h00);
    @(negedge clk);
    gie = 1'b1;
    #1 chk({7'h00, irq_branch}, 8'h01);
    @(negedge clk);
    irq_unmasked = 1'b0;
    req(5'h15, 8'h01);
    @(negedge clk);
    irq_return = 1'b1;
    @(negedge clk);
    irq_return = 1'b0;
    req(5'h15, 8'h04);
    resetn = 1'b0;
    @(negedge clk);
    chk(sfr_rdata, 8'h00);
    $display("Interrupt and reset tests done");
    end_sim();
  end

  // Whole run needs about 40040 cycles, mostly the low power wait
  initial begin
    #2500000;
    fail_count++;
    end_sim();
  end
endmodule
